// >>> mia_chk.sv
// Purpose: Port-level checker for the interrupt acceptance core
// Assumes: One clock, synchronous active-high reset
// Notes:   Sequence length is judged by a busy-cycle counter
`timescale 1ns/1ps
module mia_chk
  import mia_pkg::*;
(
  input wire logic            mclk,             // Clock
  input wire logic            rst,              // Reset
  input wire logic            insn_done,        // Instruction boundary
  input wire logic            insn_suspendable, // Suspendable instruction
  input wire logic [PC_W-1:0] pc_in,            // Program counter
  input wire logic            info_rd,          // Information read
  input wire logic [PC_W-1:0] info_addr,        // Information address
  input wire mia_accept_type  accept_info,      // Accepted source
  input wire mia_push_type    push_out,         // Stack save word
  input wire logic            seq_busy,         // Sequence running
  input wire logic            seq_done          // Sequence end
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic [5:0] busy_q;  // Busy cycles before this one
  // Counter restarts whenever the sequencer idles
  always_ff @(posedge mclk) begin
    if (rst || !seq_busy) busy_q <= 6'h00;
    else busy_q <= busy_q + 6'h01;
  end
  sequence s_info;
    info_rd ##1 !info_rd;
  endsequence
  sequence s_info_push;
    info_rd ##2 push_out.valid;
  endsequence
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_info_addr;
    info_rd |-> info_addr == INFO_ADDR;
  endproperty
  property p_info_pulse;
    info_rd |-> s_info;
  endproperty
  property p_push_order;
    info_rd |-> s_info_push;
  endproperty
  property p_boundary;
    info_rd |-> $past(insn_done || insn_suspendable);
  endproperty
  property p_accept_hold;
    info_rd |=> $stable(accept_info);
  endproperty
  property p_push_pc;
    push_out.valid |-> push_out.pc == $past(pc_in, 3);
  endproperty
  // Total busy time 17..22 leaves room for busy starting after accept
  property p_len;
    seq_done |-> (busy_q >= 6'h10) && (busy_q <= 6'h15);
  endproperty
  property p_done_end;
    seq_done |=> !seq_busy;
  endproperty
  property p_quiet;
    !seq_busy |-> !push_out.valid && !seq_done;
  endproperty
  a_info_addr:   assert property (p_info_addr) else $error("info address wrong");
  a_info_pulse:  assert property (p_info_pulse) else $error("info read not one cycle");
  a_push_order:  assert property (p_push_order) else $error("push not after info read");
  a_boundary:    assert property (p_boundary) else $error("sequence not at boundary");
  a_accept_hold: assert property (p_accept_hold) else $error("accept info not held");
  a_push_pc:     assert property (p_push_pc) else $error("pushed pc wrong");
  a_len:         assert property (p_len) else $error("sequence length out of range");
  a_done_end:    assert property (p_done_end) else $error("busy after done");
  a_quiet:       assert property (p_quiet) else $error("activity while idle");
endmodule
bind mia_core mia_chk u_chk (.mclk(mclk), .rst(rst), .insn_done(insn_done), .insn_suspendable(insn_suspendable),
  .pc_in(pc_in), .info_rd(info_rd), .info_addr(info_addr), .accept_info(accept_info), .push_out(push_out),
  .seq_busy(seq_busy), .seq_done(seq_done));

// >>> mia_core.sv
// Purpose: Maskable interrupt acceptance and interrupt sequence control
// Assumes: Sources pulse irq_pulse; pipeline reports instruction boundaries
// Notes:   Source 0 has the highest fixed hardware priority
`timescale 1ns/1ps
module mia_core
  import mia_pkg::*;
(
  input  wire logic                 mclk,          // 50 MHz clock
  input  wire logic                 rst,           // Synchronous reset
  input  wire logic [7:0]           reg_addr,      // Register address
  input  wire logic [FLG_W-1:0]     reg_wdata,     // Write data
  input  wire logic                 reg_wr,        // Write strobe
  input  wire logic                 reg_rd,        // Read strobe
  output logic      [FLG_W-1:0]     reg_rdata,     // Read data, next cycle
  input  wire logic [NSRC-1:0]      irq_pulse,     // Source requests
  input  wire logic                 insn_done,     // Instruction completes
  input  wire logic                 insn_suspendable, // String/accumulate busy
  input  wire logic [2:0]           special_req,   // Special source kind
  input  wire logic                 bus_narrow,    // 8-bit bus
  input  wire logic                 vector_odd,    // Odd vector address
  input  wire logic                 sp_odd,        // Odd stack pointer
  input  wire logic [PC_W-1:0]      pc_in,         // Current program counter
  output logic                      info_rd,       // Information read strobe
  output logic      [PC_W-1:0]      info_addr,     // Information read address
  output mia_accept_type            accept_info,   // Accepted number and level
  output mia_push_type              push_out,      // Stack save word
  output logic                      seq_busy,      // Sequence in progress
  output logic                      seq_done       // Sequence finished pulse
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Level strictly above threshold; level zero never passes
  function automatic logic lvl_enabled(input logic [LVL_W-1:0] lvl,
                                       input logic [LVL_W-1:0] thr);
    lvl_enabled = (lvl != LVL_OFF) && (lvl > thr);
  endfunction

  function automatic logic [LVL_W-1:0] ipl_of(input logic [FLG_W-1:0] f);
    ipl_of = f[FLG_IPL_LSB +: LVL_W];
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [FLG_W-1:0]       flag_q;
  logic [NSRC-1:0]        pend_q;
  logic [LVL_W-1:0]       lvl_q [NSRC];
  logic [FLG_W-1:0]       temp_q;
  logic [PC_W-1:0]        pc_q;
  mia_state_type          state_q;
  logic [4:0]             cnt_q;
  logic [4:0]             len_q;
  mia_special_type        spc_q;
  mia_accept_type         acc_q;
  logic [FLG_W-1:0]       rdata_q;

  logic                   icr_sel;
  logic [SRC_W-1:0]       icr_idx;
  logic                   win_valid;
  logic [SRC_W-1:0]       win_idx;
  logic [LVL_W-1:0]       win_lvl;
  logic                   take;
  logic                   clr_accept;
  logic [4:0]             seq_len;

  assign icr_sel = (reg_addr >= ADDR_ICR0) && (reg_addr <= ADDR_ICRN);
  assign icr_idx = SRC_W'(reg_addr - ADDR_ICR0);

  // ----------------------------------------------------------------
  // Priority resolution
  // ----------------------------------------------------------------
  // Higher level wins; on a tie the lower index keeps it
  always_comb begin
    win_valid = 1'b0;
    win_idx   = '0;
    win_lvl   = LVL_OFF;
    for (int i = NSRC-1; i >= 0; i--) begin
      if (pend_q[i] && lvl_enabled(lvl_q[i], ipl_of(flag_q)) &&
          (!win_valid || lvl_q[i] >= win_lvl)) begin
        win_valid = 1'b1;
        win_idx   = SRC_W'(i);
        win_lvl   = lvl_q[i];
      end
    end
  end

  // Take at instruction end, or mid-way for suspendable instructions
  assign take = (state_q == ST_RUN) && flag_q[FLG_I_BIT] && win_valid &&
                (insn_done || insn_suspendable);

  // Sequence length from bus width, alignment and source kind
  always_comb begin
    if (bus_narrow) begin
      seq_len = SEQ_NARROW;
    end else begin
      seq_len = SEQ_BASE + 5'(vector_odd) + 5'(sp_odd);
    end
    if (special_req == SPC_DBG) begin
      seq_len = seq_len + ADD_DEBUG;
    end else if (special_req == SPC_STEP || special_req == SPC_AMATCH) begin
      seq_len = seq_len + ADD_STEP;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Special sources are taken at the same boundary, ahead of maskable
  logic take_spc;
  assign take_spc = (state_q == ST_RUN) && (special_req != SPC_NONE) && (insn_done || insn_suspendable);

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= ST_RUN;
      cnt_q   <= '0;
      len_q   <= SEQ_BASE;
      spc_q   <= SPC_NONE;
      acc_q   <= '0;
      temp_q  <= '0;
      pc_q    <= '0;
    end else begin
      case (state_q)
        ST_RUN: begin
          cnt_q <= '0;
          if (take_spc || take) begin
            state_q <= ST_INFO;
            len_q   <= seq_len;
            spc_q   <= take_spc ? mia_special_type'(special_req) : SPC_NONE;
            acc_q   <= '{valid: !take_spc, num: win_idx, lvl: win_lvl};
            pc_q    <= pc_in;
          end
        end
        ST_INFO: begin
          cnt_q   <= cnt_q + 5'h01;
          state_q <= ST_SAVE;
        end
        ST_SAVE: begin
          cnt_q   <= cnt_q + 5'h01;
          temp_q  <= flag_q;
          state_q <= ST_PUSH;
        end
        ST_PUSH: begin
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q >= len_q - 5'h02) begin
            state_q <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          cnt_q   <= '0;
          acc_q   <= '0;
          state_q <= ST_RUN;
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  assign clr_accept = (state_q == ST_INFO) && acc_q.valid;

  // ----------------------------------------------------------------
  // Flag word
  // ----------------------------------------------------------------
  // Sequence effects take priority over a software write in the same cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      flag_q <= FLG_RESET;
    end else if (state_q == ST_SAVE) begin
      flag_q[FLG_I_BIT] <= 1'b0;
      flag_q[FLG_D_BIT] <= 1'b0;
      if (spc_q != SPC_SWINT) begin
        flag_q[FLG_U_BIT] <= 1'b0;
      end
    end else if (state_q == ST_LOAD) begin
      if (acc_q.valid) begin
        flag_q[FLG_IPL_LSB +: LVL_W] <= acc_q.lvl;
      end else if (spc_q == SPC_WDOG) begin
        flag_q[FLG_IPL_LSB +: LVL_W] <= IPL_WDOG;
      end else if (spc_q == SPC_RST) begin
        flag_q[FLG_IPL_LSB +: LVL_W] <= IPL_RST;
      end
    end else if (reg_wr && reg_addr == ADDR_FLAG) begin
      flag_q <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Per-source control registers
  // ----------------------------------------------------------------
  // Writes only clear the pending bit; an arriving request still sets it
  always_ff @(posedge mclk) begin
    if (rst) begin
      pend_q <= '0;
    end else begin
      for (int i = 0; i < NSRC; i++) begin
        if (irq_pulse[i]) begin
          pend_q[i] <= 1'b1;
        end else if (clr_accept && acc_q.num == SRC_W'(i)) begin
          pend_q[i] <= 1'b0;
        end else if (reg_wr && icr_sel && icr_idx == SRC_W'(i) && !reg_wdata[ICR_REQ_BIT]) begin
          pend_q[i] <= 1'b0;
        end
      end
    end
  end

  // Level fields, written independently of the pending bits
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < NSRC; i++) begin
        lvl_q[i] <= LVL_OFF;
      end
    end else if (reg_wr && icr_sel) begin
      lvl_q[icr_idx] <= reg_wdata[ICR_LVL_LSB +: LVL_W];
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Unmapped addresses read zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      rdata_q <= '0;
      if (reg_addr == ADDR_FLAG) begin
        rdata_q <= flag_q;
      end else if (reg_addr == ADDR_STATUS) begin
        rdata_q <= {8'h00, seq_busy, acc_q.valid, acc_q.lvl, acc_q.num};
      end else if (icr_sel) begin
        rdata_q[ICR_LVL_LSB +: LVL_W] <= lvl_q[icr_idx];
        rdata_q[ICR_REQ_BIT]          <= pend_q[icr_idx];
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata   = rdata_q;
  assign info_rd     = (state_q == ST_INFO);
  assign info_addr   = INFO_ADDR;
  assign accept_info = acc_q;
  assign seq_busy    = (state_q != ST_RUN);
  assign seq_done    = (state_q == ST_LOAD);
  // Push word stands for one cycle after the flags were saved
  assign push_out    = '{valid: (state_q == ST_PUSH) && (cnt_q == 5'h02), flags: temp_q, pc: pc_q};
  // INSN_MAX bounds the wait the pipeline imposes before insn_done
  logic unused_max;
  assign unused_max = (INSN_MAX == 5'h00);

endmodule

// >>> mia_far.sv
// Purpose: Peripheral sources and pipeline boundary model
// Assumes: Bench raises fire bits per source
// Notes:   Boundary spacing set by gap alone
`timescale 1ns/1ps
module mia_far (
  input  wire logic       mclk,      // Clock
  input  wire logic       rst,       // Reset
  input  wire logic [7:0] fire,      // Raise a request
  input  wire logic [3:0] gap,       // Cycles between boundaries
  output logic      [7:0] irq_pulse, // Source requests
  output logic            insn_done  // Instruction boundary
);
  // ------------------------------------------------------------
  // Sources and pipeline
  // ------------------------------------------------------------
  logic [7:0] fire_q;  // Last fire value
  logic [3:0] cnt_q;   // Boundary counter
  // One pulse per raised request, as a peripheral flag edge
  always_ff @(posedge mclk) begin
    fire_q    <= rst ? 8'h00 : fire;
    irq_pulse <= rst ? 8'h00 : (fire & ~fire_q);
  end
  // Spacing of 16 at most keeps within the longest instruction
  always_ff @(posedge mclk) begin
    if (rst || cnt_q >= gap) cnt_q <= 4'h0;
    else cnt_q <= cnt_q + 4'h1;
    insn_done <= !rst && (cnt_q >= gap);
  end
endmodule

// >>> mia_pkg.sv
// Purpose: Shared constants and types for the maskable interrupt acceptance block
// Assumes: Single 50 MHz clock, synchronous active-high reset
// Notes:   Register indices and field positions live here only
package mia_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NSRC      = 8;                 // Maskable sources
  localparam int LVL_W     = 3;                 // Priority level width
  localparam int SRC_W     = 3;                 // Source index width
  localparam int FLG_W     = 16;                // Flag word width
  localparam int PC_W      = 20;                // Program counter width

  // ----------------------------------------------------------------
  // Register map (word addresses on the plain port)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_FLAG   = 8'h00;   // Flag word
  localparam logic [7:0] ADDR_STATUS = 8'h01;   // Sequencer status
  localparam logic [7:0] ADDR_ICR0   = 8'h10;   // First control register
  localparam logic [7:0] ADDR_ICRN   = 8'h17;   // Last control register

  // Control register fields
  localparam int ICR_LVL_LSB = 0;
  localparam int ICR_REQ_BIT = 3;

  // Flag word fields
  localparam int FLG_I_BIT   = 6;               // Global enable
  localparam int FLG_D_BIT   = 2;               // Debug
  localparam int FLG_U_BIT   = 7;               // Stack select
  localparam int FLG_IPL_LSB = 12;              // Threshold field

  localparam logic [FLG_W-1:0] FLG_RESET = 16'h0000;
  localparam logic [LVL_W-1:0] LVL_OFF   = 3'h0;
  localparam logic [LVL_W-1:0] LVL_TOP   = 3'h7;
  localparam logic [LVL_W-1:0] IPL_WDOG  = 3'h7;
  localparam logic [LVL_W-1:0] IPL_RST   = 3'h0;

  // ----------------------------------------------------------------
  // Timing, in cycles
  // ----------------------------------------------------------------
  localparam logic [4:0] SEQ_BASE    = 5'h12;   // 18 cycles, all even, 16-bit
  localparam logic [4:0] SEQ_NARROW  = 5'h14;   // 20 cycles, 8-bit bus
  localparam logic [4:0] ADD_DEBUG   = 5'h02;
  localparam logic [4:0] ADD_STEP    = 5'h01;
  localparam logic [4:0] INSN_MAX    = 5'h1e;   // 30-cycle worst instruction

  // Information read address
  localparam logic [PC_W-1:0] INFO_ADDR = 20'h00000;

  // Special source kinds
  typedef enum logic [2:0] {
    SPC_NONE  = 3'h0,
    SPC_WDOG  = 3'h1,
    SPC_RST   = 3'h2,
    SPC_DBG   = 3'h3,
    SPC_STEP  = 3'h4,
    SPC_AMATCH= 3'h5,
    SPC_SWINT = 3'h6
  } mia_special_type;

  // Sequencer states, Gray-coded along the path
  typedef enum logic [2:0] {
    ST_RUN   = 3'b000,
    ST_INFO  = 3'b001,
    ST_SAVE  = 3'b011,
    ST_PUSH  = 3'b010,
    ST_LOAD  = 3'b110
  } mia_state_type;

  // Stack write carrier
  typedef struct packed {
    logic             valid;
    logic [FLG_W-1:0] flags;
    logic [PC_W-1:0]  pc;
  } mia_push_type;

  // Accepted interrupt info
  typedef struct packed {
    logic             valid;
    logic [SRC_W-1:0] num;
    logic [LVL_W-1:0] lvl;
  } mia_accept_type;

endpackage

// >>> tb_mia_core.sv
// Purpose: Self-checking bench for the interrupt acceptance core
// Assumes: 50 MHz mclk, reset held 20 cycles
// Notes:   Random values from an LFSR seeded at 32'h65ba
`timescale 1ns/1ps
module tb_mia_core;
  import mia_pkg::*;
  // ------------------------------------------------------------
  // Stimulus and tasks
  // ------------------------------------------------------------
  logic mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, susp = 1'b0;
  logic narrow = 1'b0, vodd = 1'b0, sodd = 1'b0, info_rd, seq_busy, seq_done;
  logic [7:0] reg_addr = 8'h00, fire = 8'h00;
  logic [FLG_W-1:0] reg_wdata = 16'h0000, reg_rdata, rdv;
  logic [3:0] gap = 4'h2;
  logic [2:0] special = 3'h0;
  logic [PC_W-1:0] pc = 20'h00000, info_addr;
  logic [31:0] rs = 32'h65ba;
  logic [7:0] irq;
  logic done_i;
  mia_accept_type accept_info, seen_acc;
  mia_push_type push_out, seen_push;
  int failures = 0, check_count = 0, len, k;
  always #10 mclk = ~mclk;
  mia_far u_far (.mclk(mclk), .rst(rst), .fire(fire), .gap(gap), .irq_pulse(irq), .insn_done(done_i));
  mia_core u_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_pulse(irq), .insn_done(done_i), .insn_suspendable(susp),
    .special_req(special), .bus_narrow(narrow), .vector_odd(vodd), .sp_odd(sodd), .pc_in(pc),
    .info_rd(info_rd), .info_addr(info_addr), .accept_info(accept_info), .push_out(push_out),
    .seq_busy(seq_busy), .seq_done(seq_done));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int exp_len(input logic [2:0] t, input logic n, input logic v, input logic s);
    return (n ? 20 : 18 + v + s) + (t == SPC_DBG ? 2 : 0) + ((t == SPC_STEP || t == SPC_AMATCH) ? 1 : 0);
  endfunction
  // Flags after a sequence: I and D always cleared, U kept only for software ints
  function automatic logic [FLG_W-1:0] exp_flag(input logic [FLG_W-1:0] f, input logic [2:0] l, input logic ku);
    logic [FLG_W-1:0] r;
    r = f;
    r[FLG_I_BIT] = 1'b0;
    r[FLG_D_BIT] = 1'b0;
    if (!ku) r[FLG_U_BIT] = 1'b0;
    r[FLG_IPL_LSB +: LVL_W] = l;
    return r;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [FLG_W-1:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Read data appear in the cycle after the strobe and hold until the next read
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rdv = reg_rdata;
  endtask
  task automatic shuffle;
    rs = lfsr(rs);
    pc <= rs[19:0];
    {narrow, vodd, sodd} <= rs[22:20];
    gap <= {1'b0, rs[25:23]};
  endtask
  // Counts busy cycles until done; gives up after 80 so a refused request ends
  task automatic run_seq(output int n);
    int c;
    n = 0;
    for (c = 0; c < 80 && seq_done !== 1'b1; c++) begin
      @(posedge mclk);
      #1;
      if (seq_busy === 1'b1) n++;
      if (push_out.valid === 1'b1) seen_push = push_out;
      if (info_rd === 1'b1) begin
        seen_acc = accept_info;
        special <= 3'h0;
      end
    end
  endtask
  task automatic mcase(input logic [2:0] src, input logic [2:0] lvl, input logic [2:0] thr, input logic en);
    logic acc;
    logic [7:0] a;
    logic [FLG_W-1:0] f;
    a = ADDR_ICR0 + 8'(src);
    f = {1'b0, thr, 12'h000} | (16'(en) << FLG_I_BIT);
    acc = en && (lvl > thr);
    shuffle();
    wr(ADDR_FLAG, 16'h0000);
    wr(a, 16'(lvl));
    wr(ADDR_FLAG, f);
    fire[src] <= 1'b1;
    run_seq(len);
    fire <= 8'h00;
    chk(32'(len != 0), 32'(acc));
    if (acc) chk(32'(len), exp_len(SPC_NONE, narrow, vodd, sodd));
    if (acc) chk(32'(seen_acc.num), 32'(src));
    if (acc) chk(32'(seen_push.flags), 32'(f));
    rd(a);
    chk(32'(rdv), 32'({~acc, lvl}));
    rd(ADDR_FLAG);
    chk(32'(rdv), 32'(acc ? exp_flag(f, lvl, 1'b0) : f));
    wr(a, 16'(lvl));
    wr(a, 16'(lvl) | 16'h0008);
    rd(a);
    chk(32'(rdv), 32'(lvl));
  endtask
  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    rd(ADDR_FLAG);
    chk(32'(rdv), 32'h0);
    rd(ADDR_ICR0);
    chk(32'(rdv), 32'h0);
    $display("reset test done");
    for (k = 0; k < 8; k++) begin
      rs = lfsr(rs);
      mcase(rs[2:0], 3'(k), 3'(k), 1'b1);
      mcase(rs[5:3], 3'(k + 1), 3'(k), 1'b1);
      mcase(rs[8:6], rs[11:9], 3'(k), rs[12]);
    end
    $display("threshold test done");
    wr(ADDR_FLAG, 16'h0000);
    wr(ADDR_ICR0 + 8'h02, 16'h0005);
    wr(ADDR_ICR0 + 8'h05, 16'h0005);
    wr(ADDR_FLAG, 16'h0040);
    gap <= 4'hf;
    susp <= 1'b1;
    fire <= 8'h24;
    run_seq(len);
    fire <= 8'h00;
    susp <= 1'b0;
    chk(32'(len != 0), 32'h1);
    chk(32'(seen_acc.num), 32'h2);
    wr(ADDR_ICR0 + 8'h05, 16'h0005);
    $display("tie test done");
    for (k = 1; k < 7; k++) begin
      shuffle();
      wr(ADDR_FLAG, 16'h3080);
      special <= 3'(k);
      run_seq(len);
      chk(32'(len), exp_len(3'(k), narrow, vodd, sodd));
      rd(ADDR_FLAG);
      chk(32'(rdv), 32'(exp_flag(16'h3080, k == 1 ? 3'h7 : (k == 2 ? 3'h0 : 3'h3), k == 6)));
    end
    $display("special test done");
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    tally_and_finish();
  end
endmodule
